/* File: hdl/smc_mode_ctrl.v */
// System clock selection and operating mode control block
`timescale 1ns/1ns
`default_nettype none
`include "smc_defines.vh"

module smc_mode_ctrl
#(
   parameter SETTLE_CYC = `SMC_SETTLE_CYC
)
(
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire fast_rc_osc,
   input wire slow_rc_osc,
   input wire [1:0] cfg_fast_freq,
   input wire wdt_enable,
   input wire halt_req,
   input wire wake_req,
   output reg sys_clk_en,
   output reg high_speed_clock_en,
   output reg low_speed_clock_en,
   output reg slow_rc_clock_en,
   output reg slow_rc_div8_en,
   output reg wdt_clk_en,
   output reg tbase_clk_en,
   output reg fast_rc_run,
   output reg slow_rc_run,
   output reg [1:0] fast_freq_out,
   output reg [1:0] fast_freq_strap,
   output reg cpu_run,
   output reg [4:0] mode
);

// ----------------------------------------
// Mode states, one-hot
// ----------------------------------------
localparam [4:0] ST_RUN = 5'h01;
localparam [4:0] ST_SLEEP = 5'h02;
localparam [4:0] ST_STANDBY_SLOW_ONLY_MODE = 5'h04;
localparam [4:0] ST_STANDBY_BOTH_OSC_MODE = 5'h08;
localparam [4:0] ST_STANDBY_FAST_ONLY_MODE = 5'h10;

// ----------------------------------------
// Helper functions
// ----------------------------------------
// Divider mask for a selector code, all ones = slow
function [5:0] div_mask;
   input [2:0] sel;
   begin
      case (sel)
         3'h0: div_mask = 6'h00;
         3'h1: div_mask = 6'h01;
         3'h2: div_mask = 6'h03;
         3'h3: div_mask = 6'h07;
         3'h4: div_mask = 6'h0f;
         3'h5: div_mask = 6'h1f;
         default: div_mask = 6'h3f;
      endcase
   end
endfunction

// Fold the spare frequency code onto 2 MHz
function [1:0] freq_norm;
   input [1:0] code;
   begin
      if (code == `SMC_FREQ_2M_ALT)
         freq_norm = `SMC_FREQ_2M;
      else
         freq_norm = code;
   end
endfunction

// ----------------------------------------
// Register state
// ----------------------------------------
reg [2:0] sys_clk_select; // Software selection
reg hs_osc_halt_keep; // Fast oscillator kept in halt
reg ls_osc_halt_keep; // Slow oscillator kept in halt
reg [1:0] fast_rc_freq_select; // Requested frequency
reg fast_rc_enable; // Fast oscillator enable
reg fast_rc_stable_flag; // Settled indication
reg [2:0] active_sel; // Selection now driving the clock
reg [5:0] div_cnt; // Fast clock prescaler
reg [2:0] slow_div; // Slow divide-by-eight counter
reg [15:0] settle_cnt; // Settling timer
reg enable_q; // Previous enable
reg [1:0] freq_q; // Previous frequency request
reg strap_done; // Strap captured once
reg [4:0] state; // Operating mode
reg [3:0] awaddr_q; // Held write address
reg aw_held; // Write address taken
reg [31:0] wdata_q; // Held write data
reg [3:0] wstrb_q; // Held strobes
reg w_held; // Write data taken

// ----------------------------------------
// Combinational clock plumbing
// ----------------------------------------
wire in_run = state[0];
wire fast_src = (active_sel != `SMC_SEL_SLOW);
// Fast oscillator demand per mode
// A pending fast selection also starts the oscillator, else the
// switch from slow would wait forever for the stable flag.
wire hs_on = in_run
   ? (fast_src | (sys_clk_select != `SMC_SEL_SLOW) | fast_rc_enable)
   : (state[3] | state[4]);
// Slow clock to peripherals stops in sleep and standby fast
wire ls_on = in_run | state[2] | state[3];
// Slow oscillator survives sleep only for the watchdog
wire slow_rc_osc_on = ~state[1] | wdt_enable;
wire hs_tick = fast_rc_osc & hs_on & fast_rc_stable_flag;
wire ls_tick = slow_rc_osc & slow_rc_osc_on;
// End of one period of the current system clock
wire fast_end = hs_tick
   & ((div_cnt & div_mask(active_sel)) == div_mask(active_sel));
wire cur_end = fast_src ? fast_end : ls_tick;
wire new_ready = (sys_clk_select == `SMC_SEL_SLOW)
   | fast_rc_stable_flag;
wire wr_go = aw_held & w_held & ~s_axi_bvalid;

// ----------------------------------------
// Clock source switching
// ----------------------------------------
// Selection changes only at the end of a full output period, or at once
// while the fast source is unsettled, and only once the new source runs, so no runt pulse.
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      active_sel <= `SMC_SEL_RESET;
      div_cnt <= 6'h00;
      slow_div <= 3'h0;
   end
   else
   begin
      if (active_sel != sys_clk_select
          && (cur_end || (fast_src && !fast_rc_stable_flag))
          && new_ready)
      begin
         active_sel <= sys_clk_select;
         div_cnt <= 6'h00; // New ratio starts a fresh period
      end
      else if (hs_tick)
         div_cnt <= div_cnt + 6'h01;
      if (ls_tick)
         slow_div <= slow_div + 3'h1;
   end
end

// ----------------------------------------
// Clock enable outputs
// ----------------------------------------
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      sys_clk_en <= 1'b0;
      high_speed_clock_en <= 1'b0;
      low_speed_clock_en <= 1'b0;
      slow_rc_clock_en <= 1'b0;
      slow_rc_div8_en <= 1'b0;
      wdt_clk_en <= 1'b0;
      tbase_clk_en <= 1'b0;
      fast_rc_run <= 1'b0;
      slow_rc_run <= 1'b1;
      cpu_run <= 1'b1;
      mode <= ST_RUN;
   end
   else
   begin
      // CPU clock exists only in the running state
      sys_clk_en <= in_run & cur_end;
      high_speed_clock_en <= hs_tick;
      low_speed_clock_en <= ls_tick & ls_on;
      slow_rc_clock_en <= ls_tick;
      slow_rc_div8_en <= ls_tick & (slow_div == 3'h7);
      wdt_clk_en <= ls_tick;
      tbase_clk_en <= ls_on ? ls_tick : hs_tick;
      fast_rc_run <= hs_on;
      slow_rc_run <= slow_rc_osc_on;
      cpu_run <= in_run;
      mode <= state;
   end
end

// ----------------------------------------
// Fast oscillator settling and strap
// ----------------------------------------
// Flag drops on enable or frequency change, rises after
// the settle time; the new frequency goes out only then.
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      fast_rc_stable_flag <= 1'b0;
      settle_cnt <= 16'h0000;
      enable_q <= 1'b0;
      freq_q <= `SMC_FREQ_RESET;
      fast_freq_out <= `SMC_FREQ_RESET;
      fast_freq_strap <= `SMC_FREQ_2M;
      strap_done <= 1'b0;
   end
   else
   begin
      if (!strap_done)
      begin
         // Strap caught once after reset release
         fast_freq_strap <= freq_norm(cfg_fast_freq);
         strap_done <= 1'b1;
      end
      enable_q <= fast_rc_enable;
      freq_q <= fast_rc_freq_select;
      if (!hs_on)
      begin
         fast_rc_stable_flag <= 1'b0; // Stopped oscillator
         settle_cnt <= 16'h0000;
      end
      else if ((fast_rc_enable && !enable_q)
               || freq_q != fast_rc_freq_select)
      begin
         fast_rc_stable_flag <= 1'b0;
         settle_cnt <= 16'h0000;
      end
      else if (!fast_rc_stable_flag)
      begin
         if (settle_cnt == SETTLE_CYC[15:0] - 16'h0001)
         begin
            fast_rc_stable_flag <= 1'b1;
            fast_freq_out <= freq_norm(fast_rc_freq_select);
         end
         else
            settle_cnt <= settle_cnt + 16'h0001;
      end
   end
end

// ----------------------------------------
// Operating mode machine
// ----------------------------------------
// Keep bits are sampled in the halt cycle itself.
always @(posedge aclk)
begin
   if (!aresetn)
      state <= ST_RUN;
   else
   begin
      case (state)
         ST_RUN:
            if (halt_req)
            begin
               case ({hs_osc_halt_keep, ls_osc_halt_keep})
                  2'h0: state <= ST_SLEEP;
                  2'h1: state <= ST_STANDBY_SLOW_ONLY_MODE;
                  2'h3: state <= ST_STANDBY_BOTH_OSC_MODE;
                  default: state <= ST_STANDBY_FAST_ONLY_MODE;
               endcase
            end
         default:
            if (wake_req)
               state <= ST_RUN;
      endcase
   end
end

// ----------------------------------------
// AXI4-Lite write channel
// ----------------------------------------
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      sys_clk_select <= `SMC_SEL_RESET;
      hs_osc_halt_keep <= 1'b0;
      ls_osc_halt_keep <= 1'b0;
      fast_rc_freq_select <= `SMC_FREQ_RESET;
      fast_rc_enable <= 1'b0;
   end
   else
   begin
      if (s_axi_awvalid && s_axi_awready)
      begin
         awaddr_q <= s_axi_awaddr;
         aw_held <= 1'b1;
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
         w_held <= 1'b1;
         s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= 2'h0;
         if ({awaddr_q[3:2], 2'h0} == `SMC_SYS_CLK_CTRL_OFS)
         begin
            if (wstrb_q[0])
            begin
               sys_clk_select <= wdata_q[`SMC_SEL_MSB:`SMC_SEL_LSB];
               hs_osc_halt_keep <= wdata_q[`SMC_HS_KEEP_BIT];
               ls_osc_halt_keep <= wdata_q[`SMC_LS_KEEP_BIT];
            end
         end
         else if ({awaddr_q[3:2], 2'h0} == `SMC_FAST_RC_CTRL_OFS)
         begin
            if (wstrb_q[0])
            begin
               fast_rc_freq_select <=
                  wdata_q[`SMC_FREQ_MSB:`SMC_FREQ_LSB];
               fast_rc_enable <= wdata_q[`SMC_ENABLE_BIT];
            end
         end
         else if ({awaddr_q[3:2], 2'h0} != `SMC_MODE_STAT_OFS)
            s_axi_bresp <= 2'h2; // Unmapped: slave error
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
   end
end

// ----------------------------------------
// AXI4-Lite read channel
// ----------------------------------------
always @(posedge aclk)
begin
   if (!aresetn)
   begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
   end
   else if (s_axi_arvalid && s_axi_arready)
   begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      if ({s_axi_araddr[3:2], 2'h0} == `SMC_SYS_CLK_CTRL_OFS)
         s_axi_rdata[7:0] <= {sys_clk_select, 3'h0,
            hs_osc_halt_keep, ls_osc_halt_keep};
      else if ({s_axi_araddr[3:2], 2'h0} == `SMC_FAST_RC_CTRL_OFS)
         s_axi_rdata[7:0] <= {4'h0, fast_rc_freq_select,
            fast_rc_stable_flag, fast_rc_enable};
      else if ({s_axi_araddr[3:2], 2'h0} == `SMC_MODE_STAT_OFS)
         s_axi_rdata[7:0] <= {active_sel, state};
      else
         s_axi_rresp <= 2'h2; // Unmapped: slave error
   end
   else if (s_axi_rvalid && s_axi_rready)
   begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
   end
end

endmodule
`default_nettype wire

/* File: shared/smc_defines.vh */
// Offsets, field positions, reset values and timing counts
`ifndef SMC_DEFINES_VH
`define SMC_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SMC_SYS_CLK_CTRL_OFS 4'h0
`define SMC_FAST_RC_CTRL_OFS 4'h4
`define SMC_MODE_STAT_OFS 4'h8
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMC_SEL_MSB 7
`define SMC_SEL_LSB 5
`define SMC_HS_KEEP_BIT 1
`define SMC_LS_KEEP_BIT 0
`define SMC_FREQ_MSB 3
`define SMC_FREQ_LSB 2
`define SMC_STABLE_BIT 1
`define SMC_ENABLE_BIT 0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define SMC_SEL_RESET 3'h7
`define SMC_SEL_SLOW 3'h7
`define SMC_FREQ_RESET 2'h0
`define SMC_FREQ_2M 2'h0
`define SMC_FREQ_4M 2'h1
`define SMC_FREQ_8M 2'h2
`define SMC_FREQ_2M_ALT 2'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define SMC_CLK_MHZ 25
`define SMC_SETTLE_US 16
`define SMC_SETTLE_CYC (`SMC_SETTLE_US * `SMC_CLK_MHZ)
`endif

/* File: verif/smc_mode_ctrl_properties.sv */
// Port-level checks of mode and clock gating
`timescale 1ns/1ns
`default_nettype none
module smc_mode_ctrl_props
#(
   parameter SETTLE_CYC = 400 // Settle count, handed on by the bind
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic wdt_enable,
   input wire logic slow_rc_osc,
   input wire logic cpu_run,
   input wire logic [4:0] mode,
   input wire logic sys_clk_en,
   input wire logic low_speed_clock_en,
   input wire logic wdt_clk_en,
   input wire logic fast_rc_run,
   input wire logic slow_rc_run,
   input wire logic [1:0] fast_freq_out
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Mode code and run flag leave the same register stage
   property p_onehot;
      $onehot(mode) && (cpu_run == (mode == 5'h01));
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("mode not one-hot or cpu flag disagrees");
   property p_halt;
      halt_req && cpu_run |-> ##[1:2] !cpu_run;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt did not stop the cpu");
   property p_wake;
      wake_req && !cpu_run |-> ##[1:2] cpu_run;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake did not restart the cpu");
   property p_sleep;
      mode == 5'h02 && $past(mode) == 5'h02 && $stable(wdt_enable)
      |-> !sys_clk_en && !low_speed_clock_en && !fast_rc_run
      && slow_rc_run == wdt_enable;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("clock left running in sleep");
   property p_standby_slow_only_mode;
      mode == 5'h04 && $past(mode) == 5'h04 |-> !fast_rc_run && slow_rc_run;
   endproperty
   a_standby_slow_only_mode: assert property (p_standby_slow_only_mode)
      else $error("wrong oscillators in slow-only standby");
   property p_standby_both_osc_mode;
      mode == 5'h08 && $past(mode) == 5'h08 |-> fast_rc_run && slow_rc_run;
   endproperty
   a_standby_both_osc_mode: assert property (p_standby_both_osc_mode)
      else $error("oscillator stopped in dual standby");
   property p_standby_fast_only_mode;
      mode == 5'h10 && $past(mode) == 5'h10
      |-> fast_rc_run && !low_speed_clock_en && !sys_clk_en;
   endproperty
   a_standby_fast_only_mode: assert property (p_standby_fast_only_mode)
      else $error("wrong clocks in fast-only standby");
   property p_tick;
      // Past-halt guard skips the cycle in which the run flag lags
      slow_rc_osc && cpu_run && !halt_req && !$past(halt_req)
      |=> low_speed_clock_en && wdt_clk_en;
   endproperty
   a_tick: assert property (p_tick)
      else $error("slow tick not passed on while running");
   property p_fold;
      fast_freq_out != 2'h3;
   endproperty
   a_fold: assert property (p_fold)
      else $error("unfolded frequency code");
   c_sleep: cover property (mode == 5'h02);
   c_standby_both_osc_mode: cover property (mode == 5'h08);
   c_standby_fast_only_mode: cover property (halt_req ##[1:2] mode == 5'h10);
endmodule
bind smc_mode_ctrl smc_mode_ctrl_props #(.SETTLE_CYC(SETTLE_CYC)) props_i (
   .aclk(aclk), .aresetn(aresetn), .halt_req(halt_req),
   .wake_req(wake_req), .wdt_enable(wdt_enable), .slow_rc_osc(slow_rc_osc),
   .cpu_run(cpu_run), .mode(mode), .sys_clk_en(sys_clk_en),
   .low_speed_clock_en(low_speed_clock_en), .wdt_clk_en(wdt_clk_en),
   .fast_rc_run(fast_rc_run), .slow_rc_run(slow_rc_run),
   .fast_freq_out(fast_freq_out));
`default_nettype wire

/* File: verif/smc_osc_model.sv */
// Oscillator tick model feeding the controller
`timescale 1ns/1ns
`default_nettype none
module smc_osc_model
#(
   parameter int FAST_DIV = 2, // Fast tick spacing
   parameter int SLOW_DIV = 16 // Slow tick spacing
)
(
   input wire logic aclk,
   input wire logic fast_rc_run,
   input wire logic slow_rc_run,
   output var logic fast_rc_osc,
   output var logic slow_rc_osc
);
   // ------------------------------------------------------------
   // Tick generators
   // ------------------------------------------------------------
   int fcnt = 0; // Fast phase
   int scnt = 0; // Slow phase
   initial
   begin
      fast_rc_osc = 1'h0;
      slow_rc_osc = 1'h0;
   end
   // A stopped oscillator gives no ticks at all
   always @(posedge aclk)
   begin
      fcnt <= (fcnt + 1) % FAST_DIV;
      scnt <= (scnt + 1) % SLOW_DIV;
      fast_rc_osc <= fast_rc_run && fcnt == 0;
      slow_rc_osc <= slow_rc_run && scnt == 0;
   end
endmodule
`default_nettype wire

/* File: verif/tb_smc_mode_ctrl.sv */
// Self-checking bench for the clock and mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_smc_mode_ctrl;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int SETTLE = 20; // Short settle keeps the run brief
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic halt = 1'h0, wake = 1'h0, wdt = 1'h0;
   logic [1:0] strap = 2'h2; // Strap at the 8 MHz code
   wire awready, wready, bvalid, arready, rvalid, fosc, sosc;
   wire [1:0] bresp, rresp, fout, fstrap;
   wire [31:0] rdata;
   wire sys_en, frun, srun, cpu_run;
   wire hs_en, sr_en, d8_en, tb_en;
   wire [4:0] mode;
   int err_total = 0;
   int check_count = 0;
   smc_mode_ctrl #(.SETTLE_CYC(SETTLE)) smc_mode_ctrl_i (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .fast_rc_osc(fosc), .slow_rc_osc(sosc),
      .cfg_fast_freq(strap), .wdt_enable(wdt), .halt_req(halt),
      .wake_req(wake), .sys_clk_en(sys_en), .high_speed_clock_en(hs_en),
      .low_speed_clock_en(), .slow_rc_clock_en(sr_en),
      .slow_rc_div8_en(d8_en),
      .wdt_clk_en(), .tbase_clk_en(tb_en), .fast_rc_run(frun),
      .slow_rc_run(srun), .fast_freq_out(fout), .fast_freq_strap(fstrap),
      .cpu_run(cpu_run), .mode(mode));
   smc_osc_model smc_osc_model_i (.aclk(aclk), .fast_rc_run(frun),
      .slow_rc_run(srun), .fast_rc_osc(fosc), .slow_rc_osc(sosc));
   always #20 aclk = ~aclk;
   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1);
      chk("bresp", (a > 4'h8) ? 32'h2 : 32'h0, bresp);
      bready <= 1'h0;
      @(posedge aclk);
   endtask
   // Read one word; unmapped places answer with an error code
   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'h0;
      end
      while (rvalid !== 1'h1);
      chk("rresp", (a > 4'h8) ? 32'h2 : 32'h0, rresp);
      if (a <= 4'h8)
         chk("rdata", e, rdata);
      rready <= 1'h0;
      @(posedge aclk);
   endtask
   // One-cycle halt (1) or wake (0) pulse, then let the mode settle
   task automatic tick(input bit is_halt);
      if (is_halt)
         halt <= 1'h1;
      else
         wake <= 1'h1;
      @(posedge aclk);
      halt <= 1'h0;
      wake <= 1'h0;
      repeat (3) @(posedge aclk);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rc(4'h0, 32'he0);
      rc(4'h4, 32'h0);
      rc(4'h8, 32'he1);
      rc(4'hc, 32'h0);
      wr(4'hc, 32'hff);
      chk("strap", 32'h2, fstrap);
   endtask
   // Each new code waits for the stable flag; last matches strap
   task automatic t_freq;
      logic [1:0] code;
      logic [31:0] prev;
      prev = 32'h0;
      for (int c = 0; c < 4; c++)
      begin
         code = 2'((c * 3 + 1) % 4);
         wr(4'h4, {28'h0, code, 2'h1});
         rc(4'h4, {28'h0, code, 2'h1});
         chk("freq_hold", prev, fout);
         repeat (SETTLE + 8) @(posedge aclk);
         prev = (code == 2'h3) ? 32'h0 : 32'(code);
         rc(4'h4, {28'h0, code, 2'h3});
         chk("freq", prev, fout);
      end
   endtask
   // Source ticks counted between two system ticks, every code
   task automatic t_div;
      int n;
      for (int k = 0; k < 8; k++)
      begin
         wr(4'h0, {24'h0, 3'(k), 5'h0});
         repeat (2)
            do @(posedge aclk); while (sys_en !== 1'h1);
         n = 0;
         do
         begin
            n += (k == 7) ? int'(sosc) : int'(fosc);
            @(posedge aclk);
         end
         while (sys_en !== 1'h1);
         chk("ticks", (k == 7) ? 32'h1 : 32'(1 << k), 32'(n));
      end
   endtask
   // Peripheral taps over one full divide-by-eight period
   task automatic t_taps;
      int hs, sr, d8, tb;
      hs = 0;
      sr = 0;
      d8 = 0;
      tb = 0;
      repeat (128)
      begin
         @(posedge aclk);
         hs += int'(hs_en);
         sr += int'(sr_en);
         d8 += int'(d8_en);
         tb += int'(tb_en);
      end
      chk("hs_ticks", 32'h40, 32'(hs));
      chk("slow_rc_osc_ticks", 32'h8, 32'(sr));
      chk("div8_ticks", 32'h1, 32'(d8));
      chk("tbase_ticks", 32'h8, 32'(tb));
   endtask
   task automatic t_slow;
      chk("frun_on", 32'h1, frun);
      wr(4'h4, 32'h8);
      repeat (4) @(posedge aclk);
      chk("frun_off", 32'h0, frun);
      chk("srun", 32'h1, srun);
      // Fast selection from slow must start the stopped oscillator
      wr(4'h0, 32'h0);
      repeat (SETTLE + 40) @(posedge aclk);
      rc(4'h8, 32'h1);
      wr(4'h0, 32'he0);
      repeat (4) @(posedge aclk);
      rc(4'h8, 32'he1);
      chk("frun_idle", 32'h0, frun);
   endtask
   // Keep codes 00, 01, 10, 11, then sleep with watchdog on
   task automatic t_halt;
      logic [4:0] m [5];
      m = '{5'h02, 5'h04, 5'h10, 5'h08, 5'h02};
      for (int i = 0; i < 5; i++)
      begin
         wdt <= 1'(i == 4);
         wr(4'h0, 32'he0 | 32'(i & 3));
         tick(1'h1);
         chk("mode", m[i], mode);
         chk("frun", 32'(i[1]), frun);
         chk("srun", 32'(i != 0), srun);
         wr(4'h0, 32'he3);
         chk("mode_kept", m[i], mode);
         tick(1'h0);
         chk("mode_run", 32'h1, mode);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_reset;
      t_freq;
      t_div;
      t_taps;
      t_slow;
      t_halt;
      summarize;
   end
   // Far beyond the fewer than two thousand cycles the run needs
   initial
   begin
      #400000;
      err_total++;
      summarize;
   end
endmodule
`default_nettype wire
